// ### wpm_pkg.sv
// Package for the wake packet status and address match block.
// Assumes one 25 MHz clock and word-indexed Wishbone register access.
package wpm_pkg;

    localparam int unsigned ADR_W = 13;
    localparam int unsigned IDX_W = 11;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CFG  = 11'h4A0;
    localparam logic [IDX_W-1:0] IDX_STAT = 11'h4A1;
    localparam logic [IDX_W-1:0] IDX_DA45 = 11'h4A2;
    localparam logic [IDX_W-1:0] IDX_DA23 = 11'h4A3;
    localparam logic [IDX_W-1:0] IDX_DA01 = 11'h4A4;
    localparam logic [IDX_W-1:0] IDX_IST  = 11'h4B0;
    localparam logic [IDX_W-1:0] IDX_IMSK = 11'h4B1;

    // wake_configuration fields
    localparam int unsigned C_SFDSEL = 13;
    localparam int unsigned C_GATE   = 12;
    localparam int unsigned C_LCLR   = 11;
    localparam int unsigned C_PW_HI  = 10;
    localparam int unsigned C_PW_LO  = 9;
    localparam int unsigned C_LVL    = 8;
    localparam int unsigned C_EN     = 7;
    localparam int unsigned C_SEC    = 5;
    localparam int unsigned C_PATEN  = 1;
    localparam int unsigned C_MAGEN  = 0;
    localparam logic [15:0] CFG_RST  = 16'h1000;

    // wake_event_status fields; interrupt status and mask share the low byte
    localparam int unsigned S_SRC  = 12;
    localparam int unsigned B_SFD  = 7;
    localparam int unsigned B_CRC  = 6;
    localparam int unsigned B_HACK = 5;
    localparam int unsigned B_WAKE = 4;
    localparam int unsigned B_PAT  = 1;
    localparam int unsigned B_MAG  = 0;
    localparam int unsigned FLAG_W = 8;
    localparam logic [FLAG_W-1:0] STAT_FLAGS = 8'hE3;
    localparam logic [FLAG_W-1:0] IRQ_FLAGS  = 8'hF3;

    localparam logic [7:0] SFD_ALT = 8'h5D;
    localparam logic [7:0] SFD_STD = 8'hD5;

    localparam int unsigned CLK_NS        = 40;
    localparam int unsigned PULSE_BASE_NS = 80;
    localparam int unsigned CNT_W         = 5;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADR_W-1:0]  adr;
        logic [31:0]       dat;
    } wpm_wb_req_s;

    // One received frame summary, dest byte 0 in the top byte
    typedef struct packed {
        logic        done;
        logic [7:0]  sfd;
        logic        crc_ok;
        logic        magic;
        logic        pattern;
        logic        pw_ok;
        logic [47:0] dest;
    } wpm_frame_s;

endpackage

// ### wpm_flag_bank.sv
// Bank of sticky flags: hardware sets, a clear vector drops them.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module wpm_flag_bank #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] flags;
    } wpm_bank_s;

    wpm_bank_s s_r;
    wpm_bank_s s_nxt;

    always_comb begin
        // Set wins over a clear in the same cycle
        s_nxt.flags = (s_r.flags & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.flags;
endmodule

// ### wpm_wake_ind.sv
// Wake indication output: level held until cleared, or a timed pulse.
// Assumes trigger and clear are single-cycle pulses on the same clock.
`timescale 1ns/1ps
module wpm_wake_ind (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       trig,
    input  wire logic       level_mode,
    input  wire logic [1:0] width_sel,
    input  wire logic       lvl_clr,
    output logic            ind
);
    typedef struct packed {
        logic                      on;
        logic [wpm_pkg::CNT_W-1:0] cnt;
    } wpm_ind_s;

    wpm_ind_s s_r;
    wpm_ind_s s_nxt;

    // Pulse widths are given at 100 MHz; rounded up to whole local cycles
    function automatic logic [wpm_pkg::CNT_W-1:0] pulse_cycles(input logic [1:0] sel);
        int unsigned ns;
        ns = wpm_pkg::PULSE_BASE_NS << sel;
        return wpm_pkg::CNT_W'((ns + wpm_pkg::CLK_NS - 1) / wpm_pkg::CLK_NS);
    endfunction

    always_comb begin
        s_nxt = s_r;
        if (level_mode) begin
            s_nxt.cnt = '0;
            s_nxt.on  = trig | (s_r.on & ~lvl_clr);
        end else if (trig) begin
            s_nxt.on  = 1'b1;
            s_nxt.cnt = pulse_cycles(width_sel) - 1'b1;
        end else if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end else begin
            s_nxt.on = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ind = s_r.on;
endmodule

// ### wpm_wake_status.sv
// Wake packet status, destination address match and interrupt select.
// Assumes frame summaries and polarity events arrive on clk as one-cycle pulses.
//
// Notes on behaviour
// - Source bit picks wake or polarity interrupt.
// - Enabling wake forces source to wake interrupt.
// - Wrong start delimiter latches the SFD error flag.
// - Failing CRC latches the bad-CRC flag while the CRC gate is on.
// - Magic packet wrong password latches violation flag.
// - Valid pattern packet latches pattern flag.
// - Valid magic packet latches magic flag.
// - First address register holds bytes four, five.
// - Second address register holds bytes two, three.
// - Third register holds bytes zero, one; perfect match.
// - CRC gate enables the bad-CRC flag; off means silence.
// - Wake output is level or timed pulse.
// - Wake enable turns on detection.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module wpm_wake_status (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire wpm_pkg::wpm_wb_req_s wb_req,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    input  wire wpm_pkg::wpm_frame_s  frame,
    input  wire logic                 pol_evt,
    output logic                      int_bit1,
    output logic                      wake_ind,
    output logic                      irq
);
    typedef struct packed {
        logic [15:0]               cfg;
        logic                      src;
        logic [47:0]               da;
        logic [wpm_pkg::FLAG_W-1:0] imsk;
        logic                      ack;
        logic [31:0]               dat;
        logic                      irq;
        logic                      bit1;
    } wpm_main_s;

    localparam wpm_main_s MAIN_RST = '{
        cfg:  wpm_pkg::CFG_RST,
        src:  1'b0,
        da:   48'h0,
        imsk: '0,
        ack:  1'b0,
        dat:  32'h0,
        irq:  1'b0,
        bit1: 1'b0
    };

    wpm_main_s s_r;
    wpm_main_s s_nxt;

    logic [wpm_pkg::FLAG_W-1:0] stat_q;
    logic [wpm_pkg::FLAG_W-1:0] stat_set;
    logic [wpm_pkg::FLAG_W-1:0] stat_clr;
    logic [wpm_pkg::FLAG_W-1:0] ist_q;
    logic [wpm_pkg::FLAG_W-1:0] ist_set;
    logic [wpm_pkg::FLAG_W-1:0] ist_clr;

    logic [wpm_pkg::IDX_W-1:0] idx;
    logic                      req;
    logic                      wr_now;
    logic                      rd_now;
    logic                      lvl_clr;
    logic                      wake_trig;

    logic       en;
    logic [7:0] sfd_want;
    logic       sfd_ok;
    logic       da_ok;
    logic       ev_sfd;
    logic       ev_crc;
    logic       ev_hack;
    logic       ev_mag;
    logic       ev_pat;
    logic       good;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        return r;
    endfunction

    assign idx    = wb_req.adr[wpm_pkg::ADR_W-1:2];
    assign req    = wb_req.cyc & wb_req.stb;
    // Effects land on the edge where the master samples ack
    assign wr_now = req & s_r.ack & wb_req.we;
    assign rd_now = req & s_r.ack & ~wb_req.we;

    // Frame classification
    assign en       = s_r.cfg[wpm_pkg::C_EN];
    assign sfd_want = s_r.cfg[wpm_pkg::C_SFDSEL] ? wpm_pkg::SFD_ALT : wpm_pkg::SFD_STD;
    assign sfd_ok   = (frame.sfd == sfd_want);
    assign da_ok    = (frame.dest == s_r.da);
    assign ev_sfd   = en & frame.done & ~sfd_ok;
    // Bad CRC never passes a wake indication; the flag only shows with the gate on
    assign ev_crc   = en & frame.done & sfd_ok & ~frame.crc_ok & s_r.cfg[wpm_pkg::C_GATE];
    assign good     = en & frame.done & sfd_ok & frame.crc_ok & da_ok;
    assign ev_hack  = good & frame.magic & s_r.cfg[wpm_pkg::C_SEC] & ~frame.pw_ok;
    assign ev_mag   = good & frame.magic & ~(s_r.cfg[wpm_pkg::C_SEC] & ~frame.pw_ok);
    assign ev_pat   = good & frame.pattern;

    assign wake_trig = (ev_mag & s_r.cfg[wpm_pkg::C_MAGEN]) | (ev_pat & s_r.cfg[wpm_pkg::C_PATEN]);

    always_comb begin
        stat_set = '0;
        stat_set[wpm_pkg::B_SFD]  = ev_sfd;
        stat_set[wpm_pkg::B_CRC]  = ev_crc;
        stat_set[wpm_pkg::B_HACK] = ev_hack;
        stat_set[wpm_pkg::B_PAT]  = ev_pat;
        stat_set[wpm_pkg::B_MAG]  = ev_mag;
        ist_set = stat_set;
        ist_set[wpm_pkg::B_WAKE] = wake_trig;
    end

    // Only the bits that were returned are cleared, so a flag set after capture survives
    assign stat_clr = (rd_now && idx == wpm_pkg::IDX_STAT) ?
                      (s_r.dat[wpm_pkg::FLAG_W-1:0] & wpm_pkg::STAT_FLAGS) : '0;
    assign ist_clr  = (wr_now && idx == wpm_pkg::IDX_IST && wb_req.sel[0]) ?
                      (wb_req.dat[wpm_pkg::FLAG_W-1:0] & wpm_pkg::IRQ_FLAGS) : '0;

    assign lvl_clr = wr_now && idx == wpm_pkg::IDX_CFG && wb_req.sel[1] && wb_req.dat[wpm_pkg::C_LCLR];

    wpm_flag_bank #(
        .W (wpm_pkg::FLAG_W)
    ) u_stat_flags (
        .clk (clk),
        .rst (rst),
        .set (stat_set),
        .clr (stat_clr),
        .q   (stat_q)
    );

    wpm_flag_bank #(
        .W (wpm_pkg::FLAG_W)
    ) u_irq_flags (
        .clk (clk),
        .rst (rst),
        .set (ist_set),
        .clr (ist_clr),
        .q   (ist_q)
    );

    wpm_wake_ind u_wake_ind (
        .clk        (clk),
        .rst        (rst),
        .trig       (wake_trig),
        .level_mode (s_r.cfg[wpm_pkg::C_LVL]),
        .width_sel  (s_r.cfg[wpm_pkg::C_PW_HI:wpm_pkg::C_PW_LO]),
        .lvl_clr    (lvl_clr),
        .ind        (wake_ind)
    );

    always_comb begin
        logic [15:0] st;
        st    = '0;
        s_nxt = s_r;

        // Register writes
        if (wr_now) begin
            unique case (idx)
                wpm_pkg::IDX_CFG: begin
                    s_nxt.cfg = merge16(s_r.cfg, wb_req.dat, wb_req.sel);
                    s_nxt.cfg[wpm_pkg::C_LCLR] = 1'b0;
                end
                wpm_pkg::IDX_STAT: begin
                    if (wb_req.sel[1]) begin
                        s_nxt.src = wb_req.dat[wpm_pkg::S_SRC];
                    end
                end
                wpm_pkg::IDX_DA45: s_nxt.da[15:0]  = merge16(s_r.da[15:0], wb_req.dat, wb_req.sel);
                wpm_pkg::IDX_DA23: s_nxt.da[31:16] = merge16(s_r.da[31:16], wb_req.dat, wb_req.sel);
                wpm_pkg::IDX_DA01: s_nxt.da[47:32] = merge16(s_r.da[47:32], wb_req.dat, wb_req.sel);
                wpm_pkg::IDX_IMSK: begin
                    if (wb_req.sel[0]) begin
                        s_nxt.imsk = wb_req.dat[wpm_pkg::FLAG_W-1:0] & wpm_pkg::IRQ_FLAGS;
                    end
                end
                default: begin
                end
            endcase
        end

        // Enabled wake detection owns the shared interrupt bit
        if (s_nxt.cfg[wpm_pkg::C_EN]) begin
            s_nxt.src = 1'b1;
        end

        // Single-cycle ack, then drop; read data registered with it
        s_nxt.ack = req & ~s_r.ack;
        if (req && !s_r.ack && !wb_req.we) begin
            st[wpm_pkg::S_SRC] = s_r.src;
            st[wpm_pkg::FLAG_W-1:0] = stat_q;
            unique case (idx)
                wpm_pkg::IDX_CFG:  s_nxt.dat = {16'h0, s_r.cfg};
                wpm_pkg::IDX_STAT: s_nxt.dat = {16'h0, st};
                wpm_pkg::IDX_DA45: s_nxt.dat = {16'h0, s_r.da[15:0]};
                wpm_pkg::IDX_DA23: s_nxt.dat = {16'h0, s_r.da[31:16]};
                wpm_pkg::IDX_DA01: s_nxt.dat = {16'h0, s_r.da[47:32]};
                wpm_pkg::IDX_IST:  s_nxt.dat = {24'h0, ist_q};
                wpm_pkg::IDX_IMSK: s_nxt.dat = {24'h0, s_r.imsk};
                default:           s_nxt.dat = 32'h0;
            endcase
        end else begin
            // Data stands only beside ack; a request still held after ack shows zero
            s_nxt.dat = 32'h0;
        end

        s_nxt.irq  = |(ist_q & s_r.imsk);
        s_nxt.bit1 = s_r.src ? wake_trig : pol_evt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= MAIN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.dat;
    assign int_bit1 = s_r.bit1;
    assign irq      = s_r.irq;
endmodule

// ### wpm_wake_status_properties.sv
// Port checks for the wake status block.
// Assumes a classic Wishbone master that holds its request until ack.
`timescale 1ns/1ps
module wpm_wake_status_properties (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire wpm_pkg::wpm_wb_req_s wb_req,
    input wire logic                 wb_ack_o,
    input wire logic [31:0]          wb_dat_o,
    input wire wpm_pkg::wpm_frame_s  frame,
    input wire logic                 pol_evt,
    input wire logic                 int_bit1,
    input wire logic                 wake_ind,
    input wire logic                 irq
);
    logic [15:0] cfg_r;
    logic        cfg_wr;
    logic        lclr;
    logic        good;
    logic        sfd_ok;
    assign cfg_wr = wb_ack_o && wb_req.we && wb_req.adr[12:2] == wpm_pkg::IDX_CFG;
    assign lclr   = cfg_wr && wb_req.sel[1] && wb_req.dat[11];
    assign good   = frame.done && cfg_r[7] && frame.crc_ok;
    assign sfd_ok = frame.sfd == (cfg_r[13] ? wpm_pkg::SFD_ALT : wpm_pkg::SFD_STD);
    // Shadow of the configuration; the clear bit never sticks
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= wpm_pkg::CFG_RST;
        end else if (cfg_wr) begin
            if (wb_req.sel[1])
                cfg_r[15:8] <= wb_req.dat[15:8] & 8'hF7;
            if (wb_req.sel[0])
                cfg_r[7:0] <= wb_req.dat[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_follows: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data without ack");
    a_wake_cause: assert property ($rose(wake_ind) |-> $past(good))
        else $error("wake without good frame");
    a_wake_sfd: assert property ($rose(wake_ind) |-> $past(sfd_ok))
        else $error("wake on wrong delimiter");
    a_pulse_two: assert property ($rose(wake_ind) && cfg_r[10:8] == 3'b000 |-> wake_ind[*2] ##1 !wake_ind)
        else $error("pulse not two cycles");
    a_pulse_four: assert property ($rose(wake_ind) && cfg_r[10:8] == 3'b010 |-> wake_ind[*4] ##1 !wake_ind)
        else $error("pulse not four cycles");
    a_pulse_eight: assert property ($rose(wake_ind) && cfg_r[10:8] == 3'b100 |-> wake_ind[*8] ##1 !wake_ind)
        else $error("pulse not eight cycles");
    a_level_hold: assert property (wake_ind && cfg_r[8] && !lclr |=> wake_ind)
        else $error("level dropped");
    a_src_wake: assert property ($past(cfg_r[7]) && cfg_r[7] && pol_evt && !frame.done |=> !int_bit1)
        else $error("polarity seen while wake on");
endmodule

bind wpm_wake_status wpm_wake_status_properties u_props (.clk(clk), .rst(rst), .wb_req(wb_req),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .frame(frame), .pol_evt(pol_evt), .int_bit1(int_bit1),
    .wake_ind(wake_ind), .irq(irq));

// ### wpm_remote_node.sv
// Remote node model: hands one received frame summary to the block per call.
// Assumes the block samples the summary on the rising edge of clk.
`timescale 1ns/1ps
module wpm_remote_node (
    input wire logic            clk,
    output wpm_pkg::wpm_frame_s frame
);
    initial frame = '0;
    // flg is crc_ok, magic, pattern, pw_ok
    task automatic send(input logic [7:0] sfd, input logic [3:0] flg, input logic [47:0] dest);
        @(posedge clk);
        frame <= {1'b1, sfd, flg, dest};
        @(posedge clk);
        // Fields mean nothing without done; invert them so stale values cannot pass
        frame <= {1'b0, ~sfd, ~flg, ~dest};
    endtask
endmodule

// ### test_wpm_wake_status.sv
// Testbench for the wake status block: registers, frames and interrupt.
// Assumes the package, the block, its checker and the remote node model.
`timescale 1ns/1ps
module test_wpm_wake_status;
    logic                 clk;
    logic                 rst;
    wpm_pkg::wpm_wb_req_s wb_req;
    logic                 ack;
    logic [31:0]          dat;
    wpm_pkg::wpm_frame_s  frame;
    logic                 pol_evt;
    logic                 int_bit1;
    logic                 wake_ind;
    logic                 irq;
    logic [31:0]          rd;
    int                   n_errors;
    int                   tests_run;
    int                   cycles;
    localparam logic [47:0] DEST = 48'h001122334455;
    // cfg, sfd, crc/magic/pattern/pw, expected flags
    localparam logic [35:0] TBL [13] = '{
        {16'h1083, 8'hD5, 4'hC, 8'h01}, {16'h1083, 8'hD5, 4'hA, 8'h02}, {16'h1083, 8'h5D, 4'hC, 8'h80},
        {16'h1083, 8'hD5, 4'h4, 8'h40}, {16'h10A3, 8'hD5, 4'hC, 8'h20}, {16'h10A3, 8'hD5, 4'hD, 8'h01},
        {16'h0083, 8'hD5, 4'h4, 8'h00}, {16'h3083, 8'h5D, 4'hC, 8'h01}, {16'h1483, 8'hD5, 4'hC, 8'h01},
        {16'h1283, 8'hD5, 4'hA, 8'h02}, {16'h1683, 8'hD5, 4'hC, 8'h01}, {16'h1003, 8'hD5, 4'hC, 8'h00},
        {16'h1183, 8'hD5, 4'hC, 8'h01}};

    wpm_wake_status DUT (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack_o(ack), .wb_dat_o(dat),
        .frame(frame), .pol_evt(pol_evt), .int_bit1(int_bit1), .wake_ind(wake_ind), .irq(irq));
    wpm_remote_node node (.clk(clk), .frame(frame));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            stop_test;
        end
    end

    task automatic bus(input logic we, input logic [10:0] idx, input logic [15:0] wd, input logic [1:0] sel);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, {2'b00, sel}, {idx, 2'b00}, {16'h0, wd}};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rd = dat;
        wb_req <= '0;
        @(posedge clk);
    endtask

    task automatic regs_check;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, wpm_pkg::IDX_CFG + 11'(i), 16'h0, 2'b11);
            check(rd, i == 0 ? 32'h1000 : 32'h0);
        end
        bus(1'b1, wpm_pkg::IDX_DA45, 16'h4455, 2'b11);
        bus(1'b1, wpm_pkg::IDX_DA23, 16'h2233, 2'b11);
        bus(1'b1, wpm_pkg::IDX_DA01, 16'hAB11, 2'b01);
        bus(1'b0, wpm_pkg::IDX_DA45, 16'h0, 2'b11);
        check(rd, 32'h4455);
        bus(1'b0, wpm_pkg::IDX_DA23, 16'h0, 2'b11);
        check(rd, 32'h2233);
        bus(1'b0, wpm_pkg::IDX_DA01, 16'h0, 2'b11);
        check(rd, 32'h0011);
        bus(1'b0, 11'h4BF, 16'h0, 2'b11);
        check(rd, 32'h0);
    endtask

    task automatic pol_pulse(input logic exp);
        @(posedge clk);
        pol_evt <= 1'b1;
        @(posedge clk);
        pol_evt <= 1'b0;
        #1 check(32'(int_bit1), 32'(exp));
    endtask

    task automatic src_select;
        pol_pulse(1'b1);
        bus(1'b1, wpm_pkg::IDX_STAT, 16'h1000, 2'b10);
        pol_pulse(1'b0);
        bus(1'b1, wpm_pkg::IDX_STAT, 16'h0000, 2'b10);
        bus(1'b1, wpm_pkg::IDX_CFG, 16'h1083, 2'b11);
        bus(1'b0, wpm_pkg::IDX_STAT, 16'h0, 2'b11);
        check(rd, 32'h1000);
        pol_pulse(1'b0);
    endtask

    task automatic frames;
        logic [35:0] e;
        for (int i = 0; i < 13; i++) begin
            e = TBL[i];
            bus(1'b1, wpm_pkg::IDX_CFG, e[35:20], 2'b11);
            node.send(e[19:12], e[11:8], DEST);
            #1 check(32'(int_bit1), 32'(|e[1:0]));
            repeat (3) @(posedge clk);
            // Three cycles after the rise only the shortest pulse has ended
            check(32'(wake_ind), 32'((e[28] || e[30:29] != 2'b00) && |e[1:0]));
            bus(1'b0, wpm_pkg::IDX_STAT, 16'h0, 2'b11);
            check({24'h0, rd[7:0]}, {24'h0, e[7:0]});
            bus(1'b0, wpm_pkg::IDX_STAT, 16'h0, 2'b11);
            check({24'h0, rd[7:0]}, 32'h0);
            bus(1'b1, wpm_pkg::IDX_CFG, e[35:20] | 16'h0800, 2'b11);
            // Let the longest pulse run out before judging the level clear
            repeat (4) @(posedge clk);
            check(32'(wake_ind), 32'h0);
        end
    endtask

    task automatic irq_path;
        bus(1'b1, wpm_pkg::IDX_CFG, 16'h1083, 2'b11);
        // Frames above leave interrupt status behind
        bus(1'b1, wpm_pkg::IDX_IST, 16'h00FF, 2'b01);
        bus(1'b1, wpm_pkg::IDX_IMSK, 16'h0001, 2'b11);
        for (int m = 1; m >= 0; m--) begin
            node.send(8'hD5, 4'hC, DEST);
            repeat (3) @(posedge clk);
            check(32'(irq), 32'(m));
            bus(1'b0, wpm_pkg::IDX_IST, 16'h0, 2'b11);
            check(rd, 32'h11);
            bus(1'b1, wpm_pkg::IDX_IST, 16'h0011, 2'b11);
            repeat (2) @(posedge clk);
            check(32'(irq), 32'h0);
            bus(1'b1, wpm_pkg::IDX_IMSK, 16'h0000, 2'b11);
        end
    endtask

    initial begin
        rst = 1'b1;
        wb_req = '0;
        pol_evt = 1'b0;
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        regs_check();
        src_select();
        frames();
        irq_path();
        stop_test();
    end
endmodule
